/* core/tspc_regs.svh */
// Purpose: named constants of the TFT source timing front end
// Assumes: included by the package and the core
// Notes: porch figures are plain defaults
`ifndef TSPC_REGS_SVH
`define TSPC_REGS_SVH
// ----------------------------------------
// Strap bit positions, pixel domain
// ----------------------------------------
`define TSPC_ST_EDGE 0
`define TSPC_ST_MODE 1
`define TSPC_ST_INV 2
`define TSPC_ST_RES 3
`define TSPC_ST_DITH_N 4
`define TSPC_ST_SHIFT 5
`define TSPC_ST_SCAN 6
`define TSPC_ST_GORD 7
`define TSPC_ST_STBY_N 8
`define TSPC_STRAP_RST 9'h172
// ----------------------------------------
// Strap bit positions, system domain
// ----------------------------------------
`define TSPC_SS_TEST 0
`define TSPC_SS_ADAPTIVE_BACKLIGHT 1
`define TSPC_SS_COMP 2
`define TSPC_SS_GAMMA 3
`define TSPC_SS_SER 4
// ----------------------------------------
// Panel timing
// ----------------------------------------
`define TSPC_HBP 11'h02e
`define TSPC_VBP 10'h017
`define TSPC_HACT 11'h320
`define TSPC_XLAST 10'h31f
`define TSPC_LINES_LO 10'h1e0
`define TSPC_LINES_HI 10'h258
`define TSPC_CH_FIRST 11'h001
`define TSPC_CH_LAST 11'h4b0
`define TSPC_CH_STEP 11'h003
`define TSPC_HCNT_MAX 11'h7ff
// ----------------------------------------
// Serial port
// ----------------------------------------
`define TSPC_SPI_BITS 5'h10
`define TSPC_SPI_HALF 5'h08
`define TSPC_SPI_ADDR_BLCAP 7'h01
`define TSPC_BLCAP_RST 8'hff
`endif

/* core/tspc_pkg.sv */
// Purpose: shared types of the TFT source timing front end
// Assumes: tspc_regs.svh on the include path
// Notes: lane and strap types only; the core keeps one struct per clock domain
`include "tspc_regs.svh"
package tspc_pkg;
  typedef logic [7:0] tspc_lane_t;
  typedef logic [8:0] tspc_strap_t;
endpackage

/* core/tspc_core.sv */
// Purpose: pixel capture, panel timing, strap control, backlight and serial port
// Assumes: pixel clock unrelated to i_clk; straps quasi-static
// Notes: pixel outputs live on the pixel clock, the rest on i_clk
//
// Summary of operation
// [RULE1] Capture on falling pixel clock edge when edge select low, rising when high.
// [RULE2] Lanes are red, green, blue; bit 0 least significant.
// [RULE3] Host drives 18-bit colour on bits 7:2 and grounds bits 1:0.
// [RULE4] Sync inputs are active low on both sides.
// [RULE5] Mode pin low gives sync-timed input, high gives data-enable input.
// [RULE6] In data-enable mode pixels are taken only while enable is high.
// [RULE7] Serial select high: pins are serial clock/data; low: 2-bit backlight mode.
// [RULE8] Serial data pin is two-way and carries only backlight commands.
// [RULE9] Serial access only while chip select is low; unused select tied high.
// [RULE10] Global reset low resets all logic; high allows operation.
// [RULE11] Inversion select low gives 2-dot, high gives 1-dot polarity.
// [RULE12] Resolution select low gives 800x480 timing, high gives 800x600.
// [RULE13] Dither enable low dithers 8-bit to 6-bit; high bypasses it.
// [RULE14] Gamma select low uses internal table, high external references.
// [RULE15] Gate order low: flag high, ascending; high: flag low, pair swap.
// [RULE16] Compensation outputs follow the compensation enable pin.
// [RULE17] Standby low stops the core and floats all outputs.
// [RULE18] Shift direction high loads channels 1 to 1200, low descending.
// [RULE19] Scan low: start on second output, flag low; high: first, flag high.
// [RULE20] Self test high gives a built-in pattern without the pixel clock.
// [RULE21] Adaptive enable low: plain backlight enable; high: content-driven PWM.
// [RULE22] Plain backlight output low switches off, high switches on.
// [RULE23] Sync lines are back porch, active pixels, front porch; first after porch.
// [RULE24] Straps are synchronised and applied only at frame boundaries; system-domain straps apply as soon as synchronised.
`timescale 1ns/1ps
`include "tspc_regs.svh"
module tspc_core (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_pixel_clock_in,
  input wire tspc_pkg::tspc_lane_t i_red_lane,
  input wire tspc_pkg::tspc_lane_t i_green_lane,
  input wire tspc_pkg::tspc_lane_t i_blue_lane,
  input wire logic i_hsync_n,
  input wire logic i_vsync_n,
  input wire logic i_pixel_valid,
  input wire logic i_clock_edge_select,
  input wire logic i_mode_select,
  input wire logic i_inversion_select,
  input wire logic i_resolution_select,
  input wire logic i_dither_enable_n,
  input wire logic i_shift_direction,
  input wire logic i_scan_direction,
  input wire logic i_gate_order_select,
  input wire logic i_standby_n,
  input wire logic i_global_reset_n,
  input wire logic i_self_test,
  input wire logic i_adaptive_backlight_enable,
  input wire logic i_compensation_enable,
  input wire logic i_gamma_source_select,
  input wire logic i_serial_or_hw_select,
  input wire logic i_serial_select_n,
  input wire logic i_scl_backlight_mode_lsb,
  input wire logic i_sda_backlight_mode_msb,
  output logic o_sda_out,
  output logic o_sda_oe,
  output logic [5:0] o_src_red,
  output logic [5:0] o_src_green,
  output logic [5:0] o_src_blue,
  output logic o_src_valid,
  output logic o_src_polarity,
  output logic [10:0] o_source_channel,
  output logic [9:0] o_gate_index,
  output logic o_start_pulse_a,
  output logic o_start_pulse_b,
  output logic o_scan_direction_out,
  output logic o_gate_order_flag,
  output logic o_line_compensation_out_l,
  output logic o_line_compensation_out_r,
  output logic o_gamma_internal,
  output logic o_backlight_out,
  output logic o_outputs_enable,
  output logic [23:0] o_test_rgb,
  output logic o_test_valid
);
  import tspc_pkg::*;

  // ----------------------------------------
  // Pixel domain state
  // ----------------------------------------
  typedef struct packed {
    tspc_strap_t strap_m;
    tspc_strap_t strap_s;
    tspc_strap_t strap_a;
    logic rst_m;
    logic rst_s;
    logic [23:0] lanes_p;
    logic hs_p;
    logic vs_p;
    logic de_p;
    logic hs_q;
    logic vs_q;
    logic [10:0] hcnt;
    logic [9:0] line;
    logic [9:0] xcnt;
    logic line_had;
    logic fpar;
    logic [10:0] ccur;
    logic [17:0] rgb;
    logic valid;
    logic pol;
    logic [10:0] chan;
    logic [9:0] gate;
    logic start_a;
    logic start_b;
    logic scan_out;
    logic gate_flag;
    logic [7:0] fmax;
    logic [7:0] fword;
    logic ftog;
  } tspc_px_s;

  tspc_px_s px_q;
  tspc_px_s px_d;
  logic [23:0] neg_lanes_q;
  logic neg_hs_q;
  logic neg_vs_q;
  logic neg_de_q;
  logic px_rst_q;

  // Falling edge copy; re-timed to the rising edge below
  always_ff @(negedge i_pixel_clock_in)
  begin
    neg_lanes_q <= {i_red_lane, i_green_lane, i_blue_lane}; // [RULE2]
    neg_hs_q <= i_hsync_n;
    neg_vs_q <= i_vsync_n;
    neg_de_q <= i_pixel_valid;
  end

  logic [23:0] sel_lanes;
  logic sel_hs;
  logic sel_vs;
  logic sel_de;
  logic hs_start;
  logic vs_start;
  logic in_sync;
  logic [9:0] row;
  logic row_ok;
  logic take;
  logic [9:0] lines;
  logic [1:0] thr;
  logic [17:0] pix6;
  logic [7:0] lmax;

  // Per lane dither or truncation; host grounds bits 1:0 for 18-bit input
  for (genvar k = 0; k < 3; k++)
  begin : g_lane
    logic [8:0] sum;
    always_comb
    begin
      sum = {1'b0, sel_lanes[k*8 +: 8]} + {7'h00, thr};
      if (px_q.strap_a[`TSPC_ST_DITH_N])
        pix6[k*6 +: 6] = sel_lanes[k*8+2 +: 6]; // [RULE3] [RULE13]
      else if (sum[8])
        pix6[k*6 +: 6] = 6'h3f;
      else
        pix6[k*6 +: 6] = sum[7:2]; // [RULE13]
    end
  end

  always_comb
  begin
    px_d = px_q;
    sel_lanes = px_q.strap_a[`TSPC_ST_EDGE] ? px_q.lanes_p : neg_lanes_q; // [RULE1]
    sel_hs = px_q.strap_a[`TSPC_ST_EDGE] ? px_q.hs_p : neg_hs_q;
    sel_vs = px_q.strap_a[`TSPC_ST_EDGE] ? px_q.vs_p : neg_vs_q;
    sel_de = px_q.strap_a[`TSPC_ST_EDGE] ? px_q.de_p : neg_de_q;
    hs_start = px_q.hs_q & ~sel_hs; // [RULE4]
    vs_start = px_q.vs_q & ~sel_vs; // [RULE4]
    in_sync = ~px_q.strap_a[`TSPC_ST_MODE];
    lines = px_q.strap_a[`TSPC_ST_RES] ? `TSPC_LINES_HI : `TSPC_LINES_LO; // [RULE12]
    row = in_sync ? px_q.line - `TSPC_VBP : px_q.line;
    row_ok = in_sync ? (px_q.line >= `TSPC_VBP) && (row < lines) : (px_q.line < lines); // [RULE12]
    if (in_sync)
      take = (px_q.hcnt >= `TSPC_HBP) && (px_q.hcnt < `TSPC_HBP + `TSPC_HACT) && sel_vs; // [RULE5] [RULE23]
    else
      take = sel_de; // [RULE5] [RULE6]
    take = take && row_ok && px_q.strap_a[`TSPC_ST_STBY_N] && (px_q.xcnt <= `TSPC_XLAST); // [RULE17]
    thr = {px_q.xcnt[0] ^ row[0], row[0]};
    lmax = sel_lanes[23:16];
    if (sel_lanes[15:8] > lmax)
      lmax = sel_lanes[15:8];
    if (sel_lanes[7:0] > lmax)
      lmax = sel_lanes[7:0];
    px_d.rst_m = px_rst_q;
    px_d.rst_s = px_q.rst_m;
    px_d.strap_m = {i_standby_n, i_gate_order_select, i_scan_direction, i_shift_direction,
                    i_dither_enable_n, i_resolution_select, i_inversion_select, i_mode_select,
                    i_clock_edge_select};
    px_d.strap_s = px_q.strap_m; // [RULE24]
    px_d.lanes_p = {i_red_lane, i_green_lane, i_blue_lane};
    px_d.hs_p = i_hsync_n;
    px_d.vs_p = i_vsync_n;
    px_d.de_p = i_pixel_valid;
    px_d.hs_q = sel_hs;
    px_d.vs_q = sel_vs;
    px_d.valid = 1'b0;
    px_d.start_a = 1'b0;
    px_d.start_b = 1'b0;
    px_d.scan_out = px_q.strap_a[`TSPC_ST_SCAN]; // [RULE19]
    px_d.gate_flag = ~px_q.strap_a[`TSPC_ST_GORD]; // [RULE15]
    if (px_q.hcnt != `TSPC_HCNT_MAX)
      px_d.hcnt = px_q.hcnt + 11'h001;
    if (take)
    begin
      px_d.valid = 1'b1; // [RULE6]
      px_d.rgb = pix6;
      px_d.pol = px_q.fpar ^ px_q.xcnt[0] ^ (px_q.strap_a[`TSPC_ST_INV] ? row[0] : row[1]); // [RULE11]
      px_d.chan = px_q.ccur;
      // A line of 800 pixels fills the 1200 channels twice, so the cursor wraps
      if (px_q.strap_a[`TSPC_ST_SHIFT])
        px_d.ccur = (px_q.ccur > `TSPC_CH_LAST - `TSPC_CH_STEP) ? `TSPC_CH_FIRST : px_q.ccur + `TSPC_CH_STEP; // [RULE18]
      else
        px_d.ccur = (px_q.ccur <= `TSPC_CH_STEP) ? `TSPC_CH_LAST : px_q.ccur - `TSPC_CH_STEP; // [RULE18]
      px_d.gate = px_q.strap_a[`TSPC_ST_GORD] ? {row[9:1], row[0] ^ row[1]} : row; // [RULE15]
      px_d.xcnt = px_q.xcnt + 10'h001;
      px_d.line_had = 1'b1;
      if (lmax > px_q.fmax)
        px_d.fmax = lmax;
    end
    // Sync edge is the first clock of the back porch
    if (hs_start)
    begin
      px_d.hcnt = 11'h001; // [RULE23]
    end
    if (hs_start || (~in_sync && ~sel_de && px_q.line_had))
    begin
      px_d.xcnt = 10'h000;
      px_d.ccur = px_q.strap_a[`TSPC_ST_SHIFT] ? `TSPC_CH_FIRST : `TSPC_CH_LAST; // [RULE18]
      if (in_sync || px_q.line_had)
        px_d.line = px_q.line + 10'h001;
      px_d.line_had = 1'b0;
    end
    if (vs_start)
    begin
      px_d.strap_a = px_q.strap_s; // [RULE24]
      px_d.line = 10'h000;
      px_d.line_had = 1'b0;
      px_d.fpar = ~px_q.fpar;
      px_d.fword = px_q.fmax;
      px_d.fmax = 8'h00;
      px_d.ftog = ~px_q.ftog;
      // Start pulse and flags follow the straps that this frame applies
      px_d.start_a = px_q.strap_s[`TSPC_ST_SCAN] & px_q.strap_s[`TSPC_ST_STBY_N]; // [RULE19]
      px_d.start_b = ~px_q.strap_s[`TSPC_ST_SCAN] & px_q.strap_s[`TSPC_ST_STBY_N]; // [RULE19]
      px_d.scan_out = px_q.strap_s[`TSPC_ST_SCAN]; // [RULE19]
      px_d.gate_flag = ~px_q.strap_s[`TSPC_ST_GORD]; // [RULE15]
    end
    if (px_q.rst_s)
    begin
      px_d = '0; // [RULE10]
      px_d.rst_m = px_rst_q;
      px_d.rst_s = px_q.rst_m;
      px_d.strap_m = px_q.strap_m;
      px_d.strap_s = px_q.strap_s;
      px_d.strap_a = `TSPC_STRAP_RST;
      px_d.hs_q = 1'b1;
      px_d.vs_q = 1'b1;
      px_d.ccur = `TSPC_CH_FIRST;
      px_d.scan_out = 1'b1;
      px_d.gate_flag = 1'b1;
    end
  end

  always_ff @(posedge i_pixel_clock_in)
  begin
    px_q <= px_d;
  end

  assign o_src_red = px_q.rgb[17:12];
  assign o_src_green = px_q.rgb[11:6];
  assign o_src_blue = px_q.rgb[5:0];
  assign o_src_valid = px_q.valid;
  assign o_src_polarity = px_q.pol;
  assign o_source_channel = px_q.chan;
  assign o_gate_index = px_q.gate;
  assign o_start_pulse_a = px_q.start_a;
  assign o_start_pulse_b = px_q.start_b;
  assign o_scan_direction_out = px_q.scan_out;
  assign o_gate_order_flag = px_q.gate_flag;

  // ----------------------------------------
  // System domain state
  // ----------------------------------------
  typedef struct packed {
    logic grst_m;
    logic grst_s;
    logic stby_m;
    logic stby_s;
    logic [4:0] st_m;
    logic [4:0] st_s;
    logic scl_m;
    logic scl_s;
    logic scl_q;
    logic cs_m;
    logic cs_s;
    logic sda_m;
    logic sda_s;
    logic tog_m;
    logic tog_s;
    logic tog_q;
    logic px_rst;
    logic [15:0] sh;
    logic [4:0] bits;
    logic rd;
    logic [7:0] rdat;
    logic [7:0] cap;
    logic sda_o;
    logic sda_oe;
    logic [7:0] fmax;
    logic [7:0] pwm;
    logic bl;
    logic comp;
    logic gam;
    logic oe;
    logic [10:0] bist;
    logic [23:0] trgb;
    logic tvalid;
  } tspc_sy_s;

  tspc_sy_s sy_q;
  tspc_sy_s sy_d;
  logic sys_rst;
  logic [7:0] duty;
  logic [7:0] bar;

  always_comb
  begin
    sy_d = sy_q;
    sys_rst = i_rst | ~sy_q.grst_s; // [RULE10]
    sy_d.grst_m = i_global_reset_n;
    sy_d.grst_s = sy_q.grst_m;
    sy_d.stby_m = i_standby_n;
    sy_d.stby_s = sy_q.stby_m;
    sy_d.st_m = {i_serial_or_hw_select, i_gamma_source_select, i_compensation_enable,
                 i_adaptive_backlight_enable, i_self_test};
    sy_d.st_s = sy_q.st_m;
    sy_d.scl_m = i_scl_backlight_mode_lsb;
    sy_d.scl_s = sy_q.scl_m;
    sy_d.scl_q = sy_q.scl_s;
    sy_d.cs_m = i_serial_select_n;
    sy_d.cs_s = sy_q.cs_m;
    sy_d.sda_m = i_sda_backlight_mode_msb;
    sy_d.sda_s = sy_q.sda_m;
    sy_d.tog_m = px_q.ftog;
    sy_d.tog_s = sy_q.tog_m;
    sy_d.tog_q = sy_q.tog_s;
    sy_d.px_rst = sys_rst;
    // Word is held a whole frame after its toggle is seen here
    if (sy_q.tog_s != sy_q.tog_q)
      sy_d.fmax = px_q.fword;
    // Serial receiver; select high aborts any transfer
    if (!sy_q.st_s[`TSPC_SS_SER] || sy_q.cs_s)
    begin
      sy_d.bits = 5'h00; // [RULE9]
      sy_d.rd = 1'b0;
      sy_d.sda_oe = 1'b0;
    end
    else if (sy_q.scl_s && !sy_q.scl_q && sy_q.bits != `TSPC_SPI_BITS)
    begin
      sy_d.sh = {sy_q.sh[14:0], sy_q.sda_s}; // [RULE7]
      sy_d.bits = sy_q.bits + 5'h01;
      if (sy_q.bits == `TSPC_SPI_HALF - 5'h01)
      begin
        sy_d.rd = sy_q.sh[6];
        sy_d.rdat = ({sy_q.sh[5:0], sy_q.sda_s} == `TSPC_SPI_ADDR_BLCAP) ? sy_q.cap : 8'h00; // [RULE8]
      end
      if (sy_q.bits == `TSPC_SPI_BITS - 5'h01 && !sy_q.rd && sy_q.sh[13:7] == `TSPC_SPI_ADDR_BLCAP)
        sy_d.cap = {sy_q.sh[6:0], sy_q.sda_s}; // [RULE8]
    end
    else if (!sy_q.scl_s && sy_q.scl_q && sy_q.rd && sy_q.bits != `TSPC_SPI_BITS)
    begin
      sy_d.sda_o = sy_q.rdat[7]; // [RULE8]
      sy_d.rdat = {sy_q.rdat[6:0], 1'b0};
      sy_d.sda_oe = sy_q.stby_s;
    end
    else if (sy_q.bits == `TSPC_SPI_BITS)
      sy_d.sda_oe = 1'b0;
    duty = (sy_q.fmax > sy_q.cap) ? sy_q.cap : sy_q.fmax;
    if (!sy_q.st_s[`TSPC_SS_SER])
      duty = duty >> {sy_q.sda_s, sy_q.scl_s}; // [RULE7]
    sy_d.pwm = sy_q.pwm + 8'h01;
    if (!sy_q.stby_s)
      sy_d.bl = 1'b0; // [RULE22]
    else if (sy_q.st_s[`TSPC_SS_ADAPTIVE_BACKLIGHT])
      sy_d.bl = sy_q.pwm < duty; // [RULE21]
    else
      sy_d.bl = 1'b1; // [RULE21] [RULE22]
    sy_d.comp = sy_q.st_s[`TSPC_SS_COMP] & sy_q.stby_s; // [RULE16]
    sy_d.gam = ~sy_q.st_s[`TSPC_SS_GAMMA]; // [RULE14]
    sy_d.oe = sy_q.stby_s; // [RULE17]
    // Pattern runs on i_clk so no pixel clock is needed
    bar = {8{sy_q.bist[10]}};
    sy_d.bist = sy_q.bist + 11'h001;
    sy_d.tvalid = sy_q.st_s[`TSPC_SS_TEST] & sy_q.stby_s; // [RULE20]
    sy_d.trgb = sy_d.tvalid ? {bar | {8{sy_q.bist[9]}}, bar, {8{sy_q.bist[8]}}} : 24'h000000; // [RULE20]
    if (sys_rst)
    begin
      sy_d.sh = 16'h0000;
      sy_d.bits = 5'h00;
      sy_d.rd = 1'b0;
      sy_d.rdat = 8'h00;
      sy_d.cap = `TSPC_BLCAP_RST;
      sy_d.sda_o = 1'b0;
      sy_d.sda_oe = 1'b0;
      sy_d.fmax = 8'h00;
      sy_d.pwm = 8'h00;
      sy_d.bl = 1'b0;
      sy_d.comp = 1'b0;
      sy_d.gam = 1'b1;
      sy_d.oe = 1'b0;
      sy_d.bist = 11'h000;
      sy_d.trgb = 24'h000000;
      sy_d.tvalid = 1'b0;
    end
  end

  always_ff @(posedge i_clk)
  begin
    sy_q <= sy_d;
  end

  // Separate flop so the pixel synchroniser reads one clean source
  always_ff @(posedge i_clk)
  begin
    px_rst_q <= sy_q.px_rst;
  end

  assign o_sda_out = sy_q.sda_o;
  assign o_sda_oe = sy_q.sda_oe;
  assign o_line_compensation_out_l = sy_q.comp;
  assign o_line_compensation_out_r = sy_q.comp;
  assign o_gamma_internal = sy_q.gam;
  assign o_backlight_out = sy_q.bl;
  assign o_outputs_enable = sy_q.oe;
  assign o_test_rgb = sy_q.trgb;
  assign o_test_valid = sy_q.tvalid;

endmodule // tspc_core

/* verif/tspc_core_checker.sv */
// Purpose: port assertions of the source timing front end
// Assumes: straps settle within eight system clocks
// Notes: start and channel checks run on the pixel clock
`timescale 1ns/1ps
module tspc_core_checker (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_pixel_clock_in,
  input wire logic i_global_reset_n,
  input wire logic i_compensation_enable,
  input wire logic i_gamma_source_select,
  input wire logic i_self_test,
  input wire logic i_serial_select_n,
  input wire logic o_sda_oe,
  input wire logic o_src_valid,
  input wire logic [10:0] o_source_channel,
  input wire logic o_start_pulse_a,
  input wire logic o_start_pulse_b,
  input wire logic o_scan_direction_out,
  input wire logic o_line_compensation_out_l,
  input wire logic o_line_compensation_out_r,
  input wire logic o_gamma_internal,
  input wire logic o_test_valid
);
  a_start_one_hot: assert property (
    @(posedge i_pixel_clock_in) disable iff (i_rst || !i_global_reset_n) !(o_start_pulse_a && o_start_pulse_b))
    else $error("both start pulses high");
  a_start_a_flag: assert property (
    @(posedge i_pixel_clock_in) disable iff (i_rst || !i_global_reset_n) o_start_pulse_a |-> o_scan_direction_out)
    else $error("first start pulse with scan flag low");
  a_start_b_flag: assert property (
    @(posedge i_pixel_clock_in) disable iff (i_rst || !i_global_reset_n) o_start_pulse_b |-> !o_scan_direction_out)
    else $error("second start pulse with scan flag high");
  a_channel_range: assert property (
    @(posedge i_pixel_clock_in) disable iff (i_rst || !i_global_reset_n)
    o_src_valid |-> o_source_channel >= 11'h001 && o_source_channel <= 11'h4b0)
    else $error("source channel out of range");
  a_comp_off: assert property (
    @(posedge i_clk) disable iff (i_rst || !i_global_reset_n)
    (!i_compensation_enable)[*8] |-> !o_line_compensation_out_l && !o_line_compensation_out_r)
    else $error("compensation driven while disabled");
  a_gamma_internal: assert property (
    @(posedge i_clk) disable iff (i_rst || !i_global_reset_n) (!i_gamma_source_select)[*8] |-> o_gamma_internal)
    else $error("internal gamma not selected");
  a_test_off: assert property (
    @(posedge i_clk) disable iff (i_rst || !i_global_reset_n) (!i_self_test)[*8] |-> !o_test_valid)
    else $error("test pattern without self test");
  a_sda_idle: assert property (
    @(posedge i_clk) disable iff (i_rst || !i_global_reset_n) i_serial_select_n[*8] |-> !o_sda_oe)
    else $error("data pin driven while deselected");
endmodule // tspc_core_checker

bind tspc_core tspc_core_checker u_chk (.i_clk(i_clk), .i_rst(i_rst), .i_pixel_clock_in(i_pixel_clock_in),
  .i_global_reset_n(i_global_reset_n), .i_compensation_enable(i_compensation_enable),
  .i_gamma_source_select(i_gamma_source_select), .i_self_test(i_self_test), .i_serial_select_n(i_serial_select_n),
  .o_sda_oe(o_sda_oe), .o_src_valid(o_src_valid), .o_source_channel(o_source_channel),
  .o_start_pulse_a(o_start_pulse_a), .o_start_pulse_b(o_start_pulse_b), .o_scan_direction_out(o_scan_direction_out),
  .o_line_compensation_out_l(o_line_compensation_out_l), .o_line_compensation_out_r(o_line_compensation_out_r),
  .o_gamma_internal(o_gamma_internal), .o_test_valid(o_test_valid));

/* verif/tspc_host_model.sv */
// Purpose: host pixel source, one frame per toggle of i_go
// Assumes: 860 clocks a line, 28 lines a frame
// Notes: data is inverted after each capture edge
`timescale 1ns/1ps
module tspc_host_model (
  input wire logic i_pclk,
  input wire logic i_edge,
  input wire logic i_g18,
  input wire logic i_go,
  input wire logic [7:0] i_base,
  input wire logic [10:0] i_npix,
  output logic o_busy,
  output logic [7:0] o_r,
  output logic [7:0] o_g,
  output logic [7:0] o_b,
  output logic o_hs_n,
  output logic o_vs_n,
  output logic o_de
);
  int h = 0;
  int ln = 99;
  logic go_q = 1'b0;
  logic [7:0] x;
  logic [7:0] m;
  initial {o_busy, o_hs_n, o_vs_n, o_de, o_r, o_g, o_b} = {4'b0110, 24'h000000};
  always @(posedge i_pclk or negedge i_pclk)
  begin
    if (i_pclk == i_edge)
    begin
      // Wrong-edge sampling sees garbage
      {o_r, o_g, o_b} <= ~{o_r, o_g, o_b};
    end
    else
    begin
      h = (h == 859) ? 0 : h + 1;
      ln = (h == 0) ? ln + 1 : ln;
      if (i_go != go_q)
      begin
        go_q = i_go;
        h = 0;
        ln = 0;
      end
      x = 8'(h - 46);
      m = {6'h3f, {2{!i_g18}}};
      o_busy <= ln < 28;
      o_hs_n <= !(h < 4 && ln < 27);
      o_vs_n <= !(ln < 3);
      o_de <= ln >= 23 && ln < 27 && h >= 46 && h < 46 + int'(i_npix);
      o_r <= (x ^ i_base) & m;
      o_g <= (x + 8'(ln)) & m;
      o_b <= (i_base - x) & m;
    end
  end
endmodule // tspc_host_model

/* verif/test_tspc_core.sv */
// Purpose: self-checking bench of the source timing front end
// Assumes: host model drives the pixel link
// Notes: five short frames, backlight, serial port, resets
`timescale 1ns/1ps
`define CHK(s, e, v) \
  begin check_count++; if ((v) !== (e)) begin mismatches++; \
  $display("MISMATCH %s exp %0h got %0h", s, e, v); end end
module test_tspc_core;
  import tspc_pkg::*;
  logic clk = 0, pclk = 0, rst = 1, grst_n = 1, go = 0, edge_s = 1, mode = 1, inv = 0, res = 0, dith_n = 1;
  logic shift = 1, scan = 1, gos = 0, stby_n = 1, test = 0, adaptive_backlight = 0, comp = 1, gam = 0, ser = 0;
  logic cs_n = 1, scl = 1, drv = 1, drv_en = 1, k0, busy, hs_n, vs_n, de, sda, sdo_d, sda_oe;
  logic sv, pol, spa, spb, sdo, gof, cl, cr, gi, bl, oe, tv;
  logic [7:0] base = 8'h00, fc = 8'hb9, rd;
  logic [10:0] npix = 11'h320, ch;
  logic [9:0] gix, x, y;
  logic [5:0] sr, sg, sb;
  logic [23:0] trgb;
  logic [31:0] seed = 32'd37;
  tspc_lane_t r, g, b;
  int mismatches = 0, check_count = 0, n = 0, na = 0, nb = 0;
  initial forever #5 clk = ~clk;
  initial #1.3 forever #3 pclk = ~pclk;
  // Pull-up on the shared data pin
  assign sda = sda_oe ? sdo_d : (drv_en ? drv : 1'b1);
  tspc_host_model u_host (.i_pclk(pclk), .i_edge(fc[7]), .i_g18(fc[5]), .i_go(go), .i_base(base), .i_npix(npix),
    .o_busy(busy), .o_r(r), .o_g(g), .o_b(b), .o_hs_n(hs_n), .o_vs_n(vs_n), .o_de(de));
  tspc_core u_dut (.i_clk(clk), .i_rst(rst), .i_pixel_clock_in(pclk), .i_red_lane(r), .i_green_lane(g),
    .i_blue_lane(b), .i_hsync_n(hs_n), .i_vsync_n(vs_n), .i_pixel_valid(de), .i_clock_edge_select(edge_s),
    .i_mode_select(mode), .i_inversion_select(inv), .i_resolution_select(res), .i_dither_enable_n(dith_n),
    .i_shift_direction(shift), .i_scan_direction(scan), .i_gate_order_select(gos), .i_standby_n(stby_n),
    .i_global_reset_n(grst_n), .i_self_test(test), .i_adaptive_backlight_enable(adaptive_backlight), .i_compensation_enable(comp),
    .i_gamma_source_select(gam), .i_serial_or_hw_select(ser), .i_serial_select_n(cs_n),
    .i_scl_backlight_mode_lsb(scl), .i_sda_backlight_mode_msb(sda), .o_sda_out(sdo_d), .o_sda_oe(sda_oe),
    .o_src_red(sr), .o_src_green(sg), .o_src_blue(sb), .o_src_valid(sv), .o_src_polarity(pol),
    .o_source_channel(ch), .o_gate_index(gix), .o_start_pulse_a(spa), .o_start_pulse_b(spb),
    .o_scan_direction_out(sdo), .o_gate_order_flag(gof), .o_line_compensation_out_l(cl),
    .o_line_compensation_out_r(cr), .o_gamma_internal(gi), .o_backlight_out(bl), .o_outputs_enable(oe),
    .o_test_rgb(trgb), .o_test_valid(tv));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Frame straps in fc: edge, mode, dither_n, shift, scan, order, inversion, standby_n
  function automatic logic [5:0] q6(input logic [7:0] v, input logic [9:0] px, input logic [9:0] py);
    logic [8:0] s;
    s = {1'b0, v} + (fc[5] ? 9'h000 : {7'h00, px[0] ^ py[0], py[0]});
    return s[8] ? 6'h3f : s[7:2];
  endfunction
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  always @(negedge pclk)
  begin
    na += int'(spa);
    nb += int'(spb);
    if (sv)
    begin
      x = 10'(n % 800);
      y = 10'(n / 800);
      `CHK("chan", fc[4] ? 11'(1 + 3 * (x % 400)) : 11'(1200 - 3 * (x % 400)), ch)
      `CHK("gate", fc[2] ? y ^ {9'h000, y[1]} : y, gix)
      `CHK("red", q6(x[7:0] ^ base, x, y), sr)
      `CHK("green", q6(x[7:0] + 8'(y) + 8'd23, x, y), sg)
      `CHK("blue", q6(base - x[7:0], x, y), sb)
      `CHK("flags", {fc[3], !fc[2]}, {sdo, gof})
      if (n == 0) k0 = pol ^ x[0] ^ (fc[1] ? y[0] : y[1]);
      `CHK("polarity", k0, pol ^ x[0] ^ (fc[1] ? y[0] : y[1]))
      n++;
    end
  end
  task automatic frame(input logic [7:0] cfg, input logic [10:0] np, input int want);
    fc = cfg;
    {edge_s, mode, dith_n, shift, scan, gos, inv, stby_n} = cfg;
    npix = np;
    base = 8'(rnd());
    res = 1'(rnd());
    n = 0;
    na = 0;
    nb = 0;
    tick(40);
    go = !go;
    tick(100);
    // Late strap flips must not touch this frame
    {shift, scan, gos, inv} = ~cfg[4:1];
    for (int i = 0; i < 20000 && busy; i++) tick(1);
    tick(50);
    `CHK("pixels", want, n)
    `CHK("starts", cfg[0] ? (cfg[3] ? 1 : 16) : 0, na + 16 * nb)
    `CHK("outputs", {cfg[0], cfg[0]}, {oe, bl})
  endtask
  task automatic duty(input int want);
    int c;
    c = 0;
    tick(300);
    repeat (256) @(negedge clk) c += int'(bl);
    `CHK("duty", want, c)
  endtask
  task automatic spi(input logic sel_n, input logic [7:0] cmd, input logic [7:0] wd, output logic [7:0] got);
    logic [15:0] w;
    w = {cmd, wd};
    got = 8'h00;
    cs_n = sel_n;
    tick(5);
    for (int i = 15; i >= 0; i--)
    begin
      scl = 0;
      drv = w[i];
      drv_en = !(cmd[7] && i < 8);
      tick(5);
      if (i < 8) got[i] = sda;
      scl = 1;
      tick(5);
    end
    cs_n = 1;
    drv_en = 1;
    tick(10);
  endtask
  task automatic print_verdict();
    if (mismatches == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (95000) @(posedge clk);
    mismatches++;
    print_verdict();
  end
  initial
  begin
    tick(6);
    rst = 0;
    tick(20);
    repeat (4)
    begin
      {comp, gam, test} = 3'(rnd());
      tick(12);
      `CHK("statics", {comp, comp, !gam, test}, {cl, cr, gi, tv})
      `CHK("test rgb", 1'b1, test || trgb == 24'h000000)
    end
    frame(8'b10111001, 11'h320, 3200);
    frame(8'b01000111, 11'h324, 3200);
    // Frame maximum is handed over one frame late; full-range frame goes third
    frame(8'b00001101, 11'h320, 3200);
    frame(8'b11110011, 11'h320, 3200);
    adaptive_backlight = 1;
    for (int md = 0; md < 4; md++)
    begin
      {drv, scl} = 2'(md);
      duty(255 >> md);
    end
    ser = 1;
    {drv, scl} = 2'b11;
    spi(1'b0, 8'h01, 8'h40, rd);
    duty(64);
    spi(1'b1, 8'h01, 8'h08, rd);
    duty(64);
    spi(1'b0, 8'h81, 8'h00, rd);
    `CHK("read", 8'h40, rd)
    spi(1'b0, 8'h85, 8'h00, rd);
    `CHK("read other", 8'h00, rd)
    adaptive_backlight = 0;
    duty(256);
    frame(8'b10111000, 11'h320, 0);
    gam = 1;
    grst_n = 0;
    tick(10);
    `CHK("reset state", 3'b100, {gi, oe, tv})
    grst_n = 1;
    tick(10);
    `CHK("after reset", 1'b0, gi)
    print_verdict();
  end
endmodule // test_tspc_core
